// [hw/cmsm_pkg.sv]
// shared constants and types for the channel mode state machine
package cmsm_pkg;
    // ********************************************************
    // state encoding
    // ********************************************************
    typedef enum logic [3:0] {
        INIT_STATE         = 4'h0,
        IDLE_WAIT_STATE    = 4'h1,
        DECISION_STATE     = 4'h2,
        IDENT_MATCH_STATE  = 4'h3,
        SELECTED_STATE     = 4'h4,
        ACCEPT_REPLY_STATE = 4'h5,
        REFUSE_REPLY_STATE = 4'h6,
        REPLY_WINDOW_STATE = 4'h7,
        SLEEP_STATE        = 4'h8
    } cmsm_state_e;

    typedef enum logic [1:0] {
        MODE_SLEEP = 2'h0,
        MODE_RESET = 2'h1,
        MODE_STBY  = 2'h2,
        MODE_ACT   = 2'h3
    } cmsm_mode_e;

    // ********************************************************
    // mode packet codes and run thresholds
    // ********************************************************
    localparam logic [1:0] CODE_ZEROS       = 2'h0;
    localparam logic [1:0] CODE_ONES        = 2'h3;
    localparam int         ONES_W           = 9;
    localparam int         ZEROS_W          = 4;
    localparam logic [7:0] WAKE_RUN_MIN     = 8'h01;
    localparam logic [7:0] WAKE_RUN_MAX     = 8'h04;
    localparam logic [8:0] RESET_RUN_MIN    = 9'h110;
    localparam logic [3:0] WAKE_HOLD_WINDOW = 4'hA;
    localparam logic [3:0] WAKE_OFFSET      = 4'h4;
    // ones run must reach the reset threshold, so it needs a ninth bit
    localparam logic [8:0] ONES_MAX         = 9'h1FF;
    localparam logic [3:0] ZEROS_MAX        = 4'hF;
    localparam logic [3:0] RUN_LEN_W        = 4'h1;
    // bench-side reference figures and the initiator relock count
    localparam int         LINK_PERIOD_NS   = 48;
    localparam int         REF_PERIOD_NS    = 50;
    localparam int         CLK_DIV_HALF     = 1;
    localparam logic [7:0] RELOCK_CYCLES    = 8'h40;
endpackage

// [hw/cmsm_link_if.sv]
// link carrier between initiator and responding device
`timescale 1ns/1ps
interface cmsm_link_if;
    logic linkClk;
    logic busEnableLine;
    logic requestStart;
    logic transDone;

    modport initiator (
        output linkClk,
        output busEnableLine,
        output requestStart,
        output transDone
    );
    modport device (
        input  linkClk,
        input  busEnableLine,
        input  requestStart,
        input  transDone
    );
endinterface

// [hw/cmsm_run_counter.sv]
// saturating consecutive-code run counters
`timescale 1ns/1ps
module cmsm_run_counter (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       codeValid,
    input  wire logic [1:0] modePacketCode,
    output logic      [8:0] onesRunCounter,
    output logic      [3:0] zerosRunCounter
);
    always_ff @(posedge clk) begin
        if (!rstn) begin
            onesRunCounter  <= '0;
            zerosRunCounter <= '0;
        end else if (codeValid) begin
            if (modePacketCode == cmsm_pkg::CODE_ZEROS) begin
                onesRunCounter <= '0;
                if (zerosRunCounter != cmsm_pkg::ZEROS_MAX) begin
                    zerosRunCounter <= zerosRunCounter + cmsm_pkg::RUN_LEN_W;
                end
            end else if (modePacketCode == cmsm_pkg::CODE_ONES) begin
                zerosRunCounter <= '0;
                if (onesRunCounter != cmsm_pkg::ONES_MAX) begin
                    onesRunCounter <= onesRunCounter + 9'h001;
                end
            end
        end
    end
endmodule // cmsm_run_counter

// [hw/cmsm_device.sv]
// responding device end: mode state machine on the link clock
`timescale 1ns/1ps
// Function
// - nine states in four operating modes
// - power-up enters reset, registers initialised
// - after power-up settle via active into standby
// - ones run 272 or more forces reset
// - zeros code leaves reset
// - 00 counts zeros, clears ones; vice versa
// - zeros run reaching 10 gives standby
// - any ones run leaves standby
// - initiator keeps sleep request bit zero
// - transitions use runs of ones codes
// - wake run is one to four packets
// - initiator avoids reserved and undefined runs
// - active within four cycles of wake start
// - request within ten cycles else standby
// - transaction done returns to standby
// - stay reset on ones, zeros gives active
// - initiator waits relock time after reset
// - initiator refreshes wake bursts every ten cycles; this initiator sends one wake run per command, with no refresh
// - bus enable idles low
// - initiator never sends codes 01 or 10
module cmsm_device (
    cmsm_link_if.device            link,
    input  wire logic              rstn,
    output logic [1:0]             opMode_ff,
    output logic [3:0]             stateCode_ff,
    output logic                   framing_ff
);
    // ********************************************************
    // mode packet sampling: two bits per packet
    // ********************************************************
    logic                  halfSel_ff;
    logic                  firstBit_ff;
    logic [1:0]            code_ff;
    logic                  codeValid_ff;
    logic [8:0]            onesRun;
    logic [3:0]            zerosRun;
    logic [3:0]            quiet_ff;
    cmsm_pkg::cmsm_state_e state_ff;
    cmsm_pkg::cmsm_state_e nxt_state;

    // packets align on a high bit; idle low keeps the pair aligned
    always_ff @(posedge link.linkClk) begin
        if (!rstn) begin
            halfSel_ff   <= 1'b0;
            firstBit_ff  <= 1'b0;
            code_ff      <= cmsm_pkg::CODE_ZEROS;
            codeValid_ff <= 1'b0;
        end else if (halfSel_ff && !firstBit_ff && link.busEnableLine) begin
            // high bit in a second half: realign so it opens a packet
            firstBit_ff  <= 1'b1;
            codeValid_ff <= 1'b0;
        end else begin
            codeValid_ff <= halfSel_ff;
            if (!halfSel_ff) begin
                firstBit_ff <= link.busEnableLine;
            end else begin
                code_ff <= {firstBit_ff, link.busEnableLine};
            end
            halfSel_ff <= ~halfSel_ff;
        end
    end

    cmsm_run_counter uRun (
        .clk             (link.linkClk),
        .rstn            (rstn),
        .codeValid       (codeValid_ff),
        .modePacketCode  (code_ff),
        .onesRunCounter  (onesRun),
        .zerosRunCounter (zerosRun)
    );

    // ********************************************************
    // wake hold window counter
    // ********************************************************
    always_ff @(posedge link.linkClk) begin
        if (!rstn) begin
            quiet_ff <= '0;
        end else if (state_ff != cmsm_pkg::DECISION_STATE || onesRun != '0) begin
            quiet_ff <= '0;
        end else if (quiet_ff != cmsm_pkg::WAKE_HOLD_WINDOW) begin
            quiet_ff <= quiet_ff + 4'h1;
        end
    end

    // ********************************************************
    // state machine
    // ********************************************************
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            cmsm_pkg::INIT_STATE: begin
                if (zerosRun != '0) begin
                    nxt_state = cmsm_pkg::DECISION_STATE;
                end
            end
            cmsm_pkg::IDLE_WAIT_STATE: begin
                if (onesRun >= cmsm_pkg::WAKE_RUN_MIN) begin
                    nxt_state = cmsm_pkg::DECISION_STATE;
                end
            end
            cmsm_pkg::DECISION_STATE: begin
                if (link.requestStart) begin
                    nxt_state = cmsm_pkg::IDENT_MATCH_STATE;
                end else if (zerosRun >= cmsm_pkg::WAKE_HOLD_WINDOW
                             || quiet_ff == cmsm_pkg::WAKE_HOLD_WINDOW) begin
                    nxt_state = cmsm_pkg::IDLE_WAIT_STATE;
                end
            end
            cmsm_pkg::IDENT_MATCH_STATE: nxt_state = cmsm_pkg::SELECTED_STATE;
            cmsm_pkg::SELECTED_STATE:    nxt_state = cmsm_pkg::ACCEPT_REPLY_STATE;
            cmsm_pkg::ACCEPT_REPLY_STATE: nxt_state = cmsm_pkg::REPLY_WINDOW_STATE;
            cmsm_pkg::REFUSE_REPLY_STATE: nxt_state = cmsm_pkg::REPLY_WINDOW_STATE;
            cmsm_pkg::REPLY_WINDOW_STATE: begin
                if (link.transDone) begin
                    nxt_state = cmsm_pkg::IDLE_WAIT_STATE;
                end
            end
            // sleep never requested on this device; recover to standby
            cmsm_pkg::SLEEP_STATE: nxt_state = cmsm_pkg::IDLE_WAIT_STATE;
            default: nxt_state = cmsm_pkg::INIT_STATE;
        endcase
        // ones run overrides every state, including a framed transaction
        if (onesRun >= cmsm_pkg::RESET_RUN_MIN) begin
            nxt_state = cmsm_pkg::INIT_STATE;
        end
    end

    always_ff @(posedge link.linkClk) begin
        if (!rstn) begin
            state_ff <= cmsm_pkg::INIT_STATE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // power-up: a one-shot that holds framing_ff low for the first cycle out of reset
    logic bootDone_ff;
    always_ff @(posedge link.linkClk) begin
        if (!rstn) begin
            bootDone_ff <= 1'b0;
        end else begin
            bootDone_ff <= 1'b1;
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    function automatic logic [1:0] modeOf(cmsm_pkg::cmsm_state_e s);
        case (s)
            cmsm_pkg::INIT_STATE:      modeOf = cmsm_pkg::MODE_RESET;
            cmsm_pkg::IDLE_WAIT_STATE: modeOf = cmsm_pkg::MODE_STBY;
            cmsm_pkg::SLEEP_STATE:     modeOf = cmsm_pkg::MODE_SLEEP;
            default:                   modeOf = cmsm_pkg::MODE_ACT;
        endcase
    endfunction

    always_ff @(posedge link.linkClk) begin
        if (!rstn) begin
            opMode_ff    <= cmsm_pkg::MODE_RESET;
            stateCode_ff <= cmsm_pkg::INIT_STATE;
            framing_ff   <= 1'b0;
        end else begin
            opMode_ff    <= modeOf(nxt_state);
            stateCode_ff <= nxt_state;
            framing_ff   <= (nxt_state != cmsm_pkg::INIT_STATE)
                            && (nxt_state != cmsm_pkg::IDLE_WAIT_STATE)
                            && (nxt_state != cmsm_pkg::DECISION_STATE)
                            && bootDone_ff;
        end
    end
endmodule // cmsm_device

// [hw/cmsm_initiator.sv]
// initiator end: sends mode packet runs and frames transactions
`timescale 1ns/1ps
module cmsm_initiator (
    cmsm_link_if.initiator link,
    input  wire logic      ref_clk,
    input  wire logic      rstn,
    input  wire logic      cmdWake,
    input  wire logic      cmdReset,
    input  wire logic      cmdTrans,
    output logic           busy_ff
);
    typedef enum logic [1:0] {
        IN_IDLE = 2'h0,
        IN_SEND = 2'h1,
        IN_GAP  = 2'h2,
        IN_TRAN = 2'h3
    } cmsm_ini_e;

    cmsm_ini_e   st_ff;
    logic        clkDiv_ff;
    logic        bitHalf_ff;
    logic [8:0]  runLeft_ff;
    logic        wantTrans_ff;
    logic        txBit_ff;
    logic        reqStart_ff;
    logic        done_ff;
    logic [1:0]  tranCnt_ff;
    logic        relock_ff;

    // link clock derived by divider; everything here steps on its falling edge
    always_ff @(posedge ref_clk) begin
        if (!rstn) clkDiv_ff <= 1'b0;
        else       clkDiv_ff <= ~clkDiv_ff;
    end
    wire step = clkDiv_ff;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_ff        <= IN_IDLE;
            bitHalf_ff   <= 1'b0;
            runLeft_ff   <= '0;
            wantTrans_ff <= 1'b0;
            txBit_ff     <= 1'b0;
            reqStart_ff  <= 1'b0;
            done_ff      <= 1'b0;
            tranCnt_ff   <= '0;
            relock_ff    <= 1'b0;
            busy_ff      <= 1'b0;
        end else if (step) begin
            reqStart_ff <= 1'b0;
            done_ff     <= 1'b0;
            case (st_ff)
                IN_IDLE: begin
                    txBit_ff <= 1'b0;
                    busy_ff  <= 1'b0;
                    if (cmdReset) begin
                        // a few packets past the threshold so reset is seen held
                        runLeft_ff   <= cmsm_pkg::RESET_RUN_MIN
                                        + {1'b0, cmsm_pkg::WAKE_RUN_MAX};
                        wantTrans_ff <= 1'b0;
                        relock_ff    <= 1'b1;
                        tranCnt_ff   <= '0;
                        st_ff        <= IN_SEND;
                        busy_ff      <= 1'b1;
                    end else if (cmdWake || cmdTrans) begin
                        runLeft_ff   <= {1'b0, cmsm_pkg::WAKE_RUN_MIN};
                        wantTrans_ff <= cmdTrans;
                        relock_ff    <= 1'b0;
                        tranCnt_ff   <= '0;
                        st_ff        <= IN_SEND;
                        busy_ff      <= 1'b1;
                    end
                end
                IN_SEND: begin
                    txBit_ff   <= 1'b1; // code 11, both halves high
                    bitHalf_ff <= ~bitHalf_ff;
                    if (bitHalf_ff) begin
                        runLeft_ff <= runLeft_ff - 9'h001;
                        if (runLeft_ff == 9'h001) begin
                            st_ff <= IN_GAP;
                        end
                    end
                end
                IN_GAP: begin
                    txBit_ff   <= 1'b0;
                    bitHalf_ff <= 1'b0;
                    if (relock_ff) begin
                        // no transaction until the far clock has relocked
                        if (runLeft_ff == {1'b0, cmsm_pkg::RELOCK_CYCLES}) begin
                            relock_ff <= 1'b0;
                            st_ff     <= IN_IDLE;
                        end else begin
                            runLeft_ff <= runLeft_ff + 9'h001;
                        end
                    end else if (!wantTrans_ff) begin
                        st_ff <= IN_IDLE;
                    end else if (({2'h0, tranCnt_ff} + 4'h2) == cmsm_pkg::WAKE_OFFSET) begin
                        // wait until the device has reached active mode
                        reqStart_ff <= 1'b1;
                        tranCnt_ff  <= '0;
                        st_ff       <= IN_TRAN;
                    end else begin
                        tranCnt_ff <= tranCnt_ff + 2'h1;
                    end
                end
                IN_TRAN: begin
                    tranCnt_ff <= tranCnt_ff + 2'h1;
                    if (tranCnt_ff == 2'h3) begin
                        done_ff <= 1'b1;
                        st_ff   <= IN_IDLE;
                    end
                end
                default: st_ff <= IN_IDLE;
            endcase
        end
    end

    assign link.linkClk       = clkDiv_ff;
    assign link.busEnableLine = txBit_ff;
    assign link.requestStart  = reqStart_ff;
    assign link.transDone     = done_ff;
endmodule // cmsm_initiator

// [tb/cmsm_mode_chk.sv]
// concurrent checks on the link and the device mode outputs
`timescale 1ns/1ps
module cmsm_mode_chk (
    input wire logic       linkClk,
    input wire logic       rstn,
    input wire logic       busEnableLine,
    input wire logic       requestStart,
    input wire logic       transDone,
    input wire logic [1:0] opMode_ff,
    input wire logic [3:0] stateCode_ff,
    input wire logic       framing_ff
);
    localparam int HI_LIM = 548;
    logic [9:0] hiCnt_ff;
    logic [3:0] quietCnt_ff;
    logic       woke_ff;
    default clocking cb @(posedge linkClk); endclocking
    default disable iff (!rstn);
    // ********************************************************
    // helper counters
    // ********************************************************
    always_ff @(posedge linkClk) begin
        if (!rstn || !busEnableLine) hiCnt_ff <= '0;
        else if (hiCnt_ff != 10'h3FF) hiCnt_ff <= hiCnt_ff + 10'h001;
    end
    // armed only by a wake from standby; active entered from reset is left unchecked
    always_ff @(posedge linkClk) begin
        woke_ff <= rstn && ((opMode_ff == cmsm_pkg::MODE_STBY)
                   || (woke_ff && opMode_ff == cmsm_pkg::MODE_ACT));
    end
    always_ff @(posedge linkClk) begin
        if (!woke_ff || busEnableLine || framing_ff || requestStart
            || opMode_ff != cmsm_pkg::MODE_ACT) quietCnt_ff <= '0;
        else if (quietCnt_ff != 4'hF) quietCnt_ff <= quietCnt_ff + 4'h1;
    end
    // ********************************************************
    // assertions
    // ********************************************************
    reset_hold_ones_a: assert property (
        busEnableLine [*4] ##0 opMode_ff == cmsm_pkg::MODE_RESET
        |=> opMode_ff == cmsm_pkg::MODE_RESET) else $error("reset left during ones run");
    reset_state_code_a: assert property (
        opMode_ff == cmsm_pkg::MODE_RESET |-> stateCode_ff == cmsm_pkg::INIT_STATE)
        else $error("reset mode with wrong state");
    no_sleep_mode_a: assert property (opMode_ff != cmsm_pkg::MODE_SLEEP)
        else $error("sleep mode entered");
    wake_latency_a: assert property (
        $rose(busEnableLine) && opMode_ff == cmsm_pkg::MODE_STBY
        |-> ##[1:4] opMode_ff == cmsm_pkg::MODE_ACT) else $error("wake too slow");
    quiet_fallback_a: assert property (quietCnt_ff <= 4'hE)
        else $error("active mode held without request");
    done_to_standby_a: assert property (
        transDone |-> ##[1:4] opMode_ff == cmsm_pkg::MODE_STBY && !framing_ff)
        else $error("no standby after transaction");
    framing_active_a: assert property (
        framing_ff |-> opMode_ff == cmsm_pkg::MODE_ACT) else $error("framing outside active");
    long_ones_reset_a: assert property (
        hiCnt_ff >= 10'(HI_LIM) |-> opMode_ff == cmsm_pkg::MODE_RESET)
        else $error("long ones run without reset");
    request_idle_low_a: assert property (requestStart |-> !busEnableLine)
        else $error("bus enable high at request");
    standby_state_code_a: assert property (
        opMode_ff == cmsm_pkg::MODE_STBY |-> stateCode_ff == cmsm_pkg::IDLE_WAIT_STATE)
        else $error("standby mode with wrong state");
endmodule // cmsm_mode_chk

// [tb/tb_top.sv]
// self-checking bench for initiator and device joined on the link
`timescale 1ns/1ps
module tb_top;
    logic       ref_clk;
    logic       rstn;
    logic       devRstn;
    logic       cmdWake;
    logic       cmdReset;
    logic       cmdTrans;
    logic       busy;
    logic [1:0] opMode;
    logic [3:0] stateCode;
    logic       framing;
    int         hiBits;
    int         fails;
    int         samples_checked;
    cmsm_link_if link ();
    cmsm_initiator cmsm_initiator_inst (.link(link.initiator), .ref_clk(ref_clk), .rstn(rstn),
        .cmdWake(cmdWake), .cmdReset(cmdReset), .cmdTrans(cmdTrans), .busy_ff(busy));
    cmsm_device cmsm_device_inst (.link(link.device), .rstn(devRstn), .opMode_ff(opMode),
        .stateCode_ff(stateCode), .framing_ff(framing));
    cmsm_mode_chk cmsm_mode_chk_inst (.linkClk(link.linkClk), .rstn(devRstn),
        .busEnableLine(link.busEnableLine), .requestStart(link.requestStart),
        .transDone(link.transDone), .opMode_ff(opMode), .stateCode_ff(stateCode),
        .framing_ff(framing));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge link.linkClk) if (link.busEnableLine === 1'b1) hiBits++;
    // ********************************************************
    // shared tasks
    // ********************************************************
    task automatic check_val(input logic [3:0] got, input logic [3:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_mode(input logic [1:0] m, input int n, output logic ok);
        ok = 1'b0;
        for (int i = 0; i < n && !ok; i++) begin
            @(negedge ref_clk);
            ok = (opMode === m);
        end
    endtask
    // level request held until the initiator goes busy, then dropped
    task automatic issue(input int kind);
        for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge ref_clk);
        @(posedge ref_clk);
        cmdWake <= (kind == 0);
        cmdReset <= (kind == 1);
        cmdTrans <= (kind == 2);
        for (int i = 0; i < 50 && busy !== 1'b1; i++) @(posedge ref_clk);
        cmdWake <= 1'b0;
        cmdReset <= 1'b0;
        cmdTrans <= 1'b0;
    endtask
    // ********************************************************
    // scenarios
    // ********************************************************
    task automatic test_power_up();
        logic ok;
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (20) @(posedge ref_clk);
        check_val({2'h0, opMode}, 4'h1);
        check_val(stateCode, 4'h0);
        devRstn <= 1'b1;
        wait_mode(cmsm_pkg::MODE_ACT, 100, ok);
        check_val({3'h0, ok}, 4'h1);
        wait_mode(cmsm_pkg::MODE_STBY, 200, ok);
        check_val({3'h0, ok}, 4'h1);
        check_val(stateCode, 4'h1);
    endtask
    task automatic test_wake_timeout();
        logic ok;
        hiBits = 0;
        issue(0);
        wait_mode(cmsm_pkg::MODE_ACT, 20, ok);
        check_val({3'h0, ok}, 4'h1);
        wait_mode(cmsm_pkg::MODE_STBY, 60, ok);
        check_val({3'h0, ok}, 4'h1);
        check_val({3'h0, hiBits >= 2 && hiBits <= 8 && hiBits % 2 == 0}, 4'h1);
    endtask
    task automatic test_transaction();
        logic ok;
        hiBits = 0;
        issue(2);
        ok = 1'b0;
        for (int i = 0; i < 40 && !ok; i++) begin
            @(negedge ref_clk);
            ok = (framing === 1'b1);
        end
        check_val({3'h0, ok}, 4'h1);
        check_val(hiBits[3:0], 4'h2);
        wait_mode(cmsm_pkg::MODE_STBY, 60, ok);
        check_val({3'h0, ok}, 4'h1);
        check_val({3'h0, framing}, 4'h0);
    endtask
    task automatic test_reset_run();
        logic ok;
        issue(1);
        wait_mode(cmsm_pkg::MODE_RESET, 1600, ok);
        check_val({3'h0, ok}, 4'h1);
        check_val(stateCode, 4'h0);
        wait_mode(cmsm_pkg::MODE_ACT, 600, ok);
        check_val({3'h0, ok}, 4'h1);
        wait_mode(cmsm_pkg::MODE_STBY, 600, ok);
        check_val({3'h0, ok}, 4'h1);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        rstn = 1'b0;
        devRstn = 1'b0;
        cmdWake = 1'b0;
        cmdReset = 1'b0;
        cmdTrans = 1'b0;
        hiBits = 0;
        fails = 0;
        samples_checked = 0;
        test_power_up();
        test_wake_timeout();
        test_transaction();
        test_reset_run();
        test_wake_timeout();
        print_verdict();
    end
    // whole run needs well under 10000 reference cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        $display("ERROR %0t watchdog expired", $time);
        print_verdict();
    end
endmodule // tb_top
